// [plb_fabric.sv]
/*
  Top of the programmable logic block array: pin synchronisers, routing
  matrix, two logic blocks (product arrays, allocators, macrocells, pin
  cells) and the AXI4-Lite configuration slave.
  Assumes pins are asynchronous to aclk; clock pins are sampled, so their
  edges must be slower than aclk/4 to be seen.
*/
`timescale 1ns/10ps

module plb_fabric (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [plb_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]                    awprot,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [plb_pkg::DATA_W-1:0]    wdata,
  input  wire logic [plb_pkg::STRB_W-1:0]    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [plb_pkg::ADDR_W-1:0]    araddr,
  input  wire logic [2:0]                    arprot,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [plb_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic [plb_pkg::NUM_DED-1:0]   ded_in,
  input  wire logic [plb_pkg::NUM_CLK-1:0]   clk_pin,
  input  wire logic [plb_pkg::NUM_IO-1:0]    io_in,
  output logic [plb_pkg::NUM_IO-1:0]         io_out,
  output logic [plb_pkg::NUM_IO-1:0]         io_oe
);
  import plb_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic plb_region_type region_of(input logic [ADDR_W-1:0] a);
    plb_region_type r;
    r = RGN_NONE;
    if (a[TERM_BLK_BIT+1 +: 5] == TERM_BASE[TERM_BLK_BIT+1 +: 5] &&
        a[TERM_IDX_LSB +: TERM_IDX_W] < NUM_TERMS)
      r = RGN_TERM;
    else if (a[15:6] == ROUTE_BASE[15:6] &&
             a[ROUTE_IDX_LSB +: ROUTE_IDX_W] < ROUTE_WORDS)
      r = RGN_ROUTE;
    else if (a[15:3] == ALLOC_BASE[15:3])
      r = RGN_ALLOC;
    else if (a[15:7] == MC_BASE[15:7])
      r = RGN_MC;
    else if (a[15:4] == STAT_BASE[15:4] && a[STAT_IDX_LSB +: STAT_IDX_W] <= STAT_IO_IN)
      r = RGN_STAT;
    if (a[1:0] != 2'h0)
      r = RGN_NONE;
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < STRB_W; k++) begin
      if (strb[k]) begin
        r[8*k +: 8] = wdat[8*k +: 8];
      end
    end
    return r & mask;
  endfunction

  // a cluster feeds one macrocell only, so no cell can exceed 3 clusters
  function automatic logic steer_hits(input int c, input int m, input logic [1:0] code);
    logic hit;
    hit = 1'b0;
    if ((c / HALF_SIZE) == (m / HALF_SIZE)) begin
      case (code)
        STEER_DOWN: hit = (m == c - 1);
        STEER_OWN:  hit = (m == c);
        STEER_UP:   hit = (m == c + 1);
        default:    hit = 1'b0;
      endcase
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------
  logic [31:0] term_lit      [NUM_BLOCKS][NUM_TERMS];
  logic [31:0] term_cmp      [NUM_BLOCKS][NUM_TERMS];
  logic [31:0] route_w       [NUM_BLOCKS][ROUTE_WORDS];
  logic [31:0] alloc_w       [NUM_BLOCKS];
  logic [31:0] mc_w          [NUM_BLOCKS][NUM_MC];
  logic [31:0] next_term_lit [NUM_BLOCKS][NUM_TERMS];
  logic [31:0] next_term_cmp [NUM_BLOCKS][NUM_TERMS];
  logic [31:0] next_route_w  [NUM_BLOCKS][ROUTE_WORDS];
  logic [31:0] next_alloc_w  [NUM_BLOCKS];
  logic [31:0] next_mc_w     [NUM_BLOCKS][NUM_MC];

  // ----------------------------------------------------------------
  // pins and routing sources
  // ----------------------------------------------------------------
  logic [NUM_PIN_RAW-1:0] pins_sync;
  logic [NUM_IO-1:0]      io_sync;
  logic [NUM_DED-1:0]     ded_sync;
  logic [NUM_CLK-1:0]     clk_sync;
  logic [NUM_CLK-1:0]     clk_prev;
  logic [NUM_CLK-1:0]     next_clk_prev;
  logic [NUM_CLK-1:0]     clk_rise;
  logic [NUM_SRC-1:0]     src;
  wire  [NUM_IO-1:0]      mc_out;
  wire  [NUM_IO-1:0]      next_oe;
  logic [NUM_IO-1:0]      oe_q;

  plb_sync #(
    .WIDTH (NUM_PIN_RAW)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({clk_pin, ded_in, io_in}),
    .q       (pins_sync)
  );

  assign io_sync  = pins_sync[NUM_IO-1:0];
  assign ded_sync = pins_sync[NUM_IO +: NUM_DED];
  assign clk_sync = pins_sync[NUM_IO+NUM_DED +: NUM_CLK];

  always_comb begin
    next_clk_prev = clk_sync;
    clk_rise      = clk_sync & ~clk_prev;
  end

  // macrocell feedback is taken from flops, which breaks any loop
  // a configuration could build through the array
  assign src = {mc_out, io_sync, clk_sync, ded_sync};

  // ----------------------------------------------------------------
  // logic blocks
  // ----------------------------------------------------------------
  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
    logic [NUM_IN-1:0]       blk_in;
    logic [NUM_TERMS-1:0]    term_val;
    logic [NUM_CLUSTERS-1:0] cluster;
    logic [NUM_MC-1:0]       mc_sum;
    logic [NUM_MC-1:0]       oe_blk;

    always_comb begin
      for (int i = 0; i < NUM_IN; i++) begin
        logic [SRC_SEL_W-1:0] sel;
        sel = route_w[b][i / ROUTES_PER_WRD][(i % ROUTES_PER_WRD) * ROUTE_FIELD_W +: SRC_SEL_W];
        blk_in[i] = (sel < NUM_SRC) ? src[sel] : 1'b0;
      end
    end

    // disabled terms read low; an enabled empty term reads high
    always_comb begin
      for (int t = 0; t < NUM_TERMS; t++) begin
        term_val[t] = term_cmp[b][t][TERM_EN_BIT] &
                      (&((~term_lit[b][t][NUM_IN-1:0] | blk_in) &
                         (~term_cmp[b][t][NUM_IN-1:0] | ~blk_in)));
      end
    end

    always_comb begin
      for (int c = 0; c < NUM_CLUSTERS; c++) begin
        cluster[c] = |term_val[c*TERMS_PER_CLUSTER +: TERMS_PER_CLUSTER];
      end
      for (int m = 0; m < NUM_MC; m++) begin
        mc_sum[m] = 1'b0;
        for (int c = 0; c < NUM_CLUSTERS; c++) begin
          if (steer_hits(c, m, alloc_w[b][c*STEER_W +: STEER_W])) begin
            mc_sum[m] = mc_sum[m] | cluster[c];
          end
        end
      end
    end

    always_comb begin
      for (int m = 0; m < NUM_MC; m++) begin
        case (mc_w[b][m][MC_OE_LSB +: 2])
          OE_OFF:    oe_blk[m] = 1'b0;
          OE_ON:     oe_blk[m] = 1'b1;
          OE_TERM_A: oe_blk[m] = term_val[OE_TERM_BASE + 2*(m/BANK_SIZE)];
          OE_TERM_B: oe_blk[m] = term_val[OE_TERM_BASE + 2*(m/BANK_SIZE) + 1];
          default:   oe_blk[m] = 1'b0;
        endcase
      end
    end

    assign next_oe[b*NUM_MC +: NUM_MC] = oe_blk;

    for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
      plb_macrocell u_mc (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .sum        (mc_sum[m]),
        .registered (mc_w[b][m][MC_REG_BIT]),
        .invert     (mc_w[b][m][MC_INV_BIT]),
        .toggle     (mc_w[b][m][MC_TOGGLE_BIT]),
        .clk_tick   (clk_rise[mc_w[b][m][MC_CLKSEL_BIT]]),
        .clear      (term_val[CLEAR_TERM]),
        .set        (term_val[SET_TERM]),
        .out        (mc_out[b*NUM_MC + m])
      );
    end
  end

  assign io_out = mc_out;
  assign io_oe  = oe_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev <= '0;
      oe_q     <= '0;
    end else begin
      clk_prev <= next_clk_prev;
      oe_q     <= next_oe;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  plb_wr_state_type    wr_state;
  plb_wr_state_type    next_wr_state;
  logic                aw_held;
  logic                next_aw_held;
  logic                w_held;
  logic                next_w_held;
  logic [ADDR_W-1:0]   aw_addr;
  logic [ADDR_W-1:0]   next_aw_addr;
  logic [DATA_W-1:0]   w_data;
  logic [DATA_W-1:0]   next_w_data;
  logic [STRB_W-1:0]   w_strb;
  logic [STRB_W-1:0]   next_w_strb;
  logic [1:0]          next_bresp;
  plb_region_type      wr_rgn;

  assign wr_rgn  = region_of(aw_addr);
  assign awready = (wr_state == WR_COLLECT) && !aw_held;
  assign wready  = (wr_state == WR_COLLECT) && !w_held;
  assign bvalid  = (wr_state == WR_RESP);

  always_comb begin
    next_wr_state = wr_state;
    next_aw_held  = aw_held;
    next_aw_addr  = aw_addr;
    next_w_held   = w_held;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bresp    = bresp;
    case (wr_state)
      WR_COLLECT: begin
        if (awvalid && awready) begin
          next_aw_held = 1'b1;
          next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
          next_w_held = 1'b1;
          next_w_data = wdata;
          next_w_strb = wstrb;
        end
        if (next_aw_held && next_w_held) begin
          next_wr_state = WR_COMMIT;
        end
      end
      WR_COMMIT: begin
        // status words are read-only, so writing them is an error
        next_bresp    = (wr_rgn == RGN_NONE || wr_rgn == RGN_STAT) ? RESP_SLVERR : RESP_OKAY;
        next_wr_state = WR_RESP;
      end
      WR_RESP: begin
        if (bready) begin
          next_wr_state = WR_COLLECT;
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
        end
      end
      default: next_wr_state = WR_COLLECT;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_COLLECT;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= '0;
      w_data   <= '0;
      w_strb   <= '0;
      bresp    <= RESP_OKAY;
    end else begin
      wr_state <= next_wr_state;
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      bresp    <= next_bresp;
    end
  end

  // ----------------------------------------------------------------
  // configuration update
  // ----------------------------------------------------------------
  always_comb begin
    next_term_lit = term_lit;
    next_term_cmp = term_cmp;
    next_route_w  = route_w;
    next_alloc_w  = alloc_w;
    next_mc_w     = mc_w;
    if (wr_state == WR_COMMIT) begin
      case (wr_rgn)
        RGN_TERM: begin
          if (aw_addr[WORD_SEL_BIT]) begin
            next_term_cmp[aw_addr[TERM_BLK_BIT]][aw_addr[TERM_IDX_LSB +: TERM_IDX_W]] =
              merge(term_cmp[aw_addr[TERM_BLK_BIT]][aw_addr[TERM_IDX_LSB +: TERM_IDX_W]],
                    w_data, w_strb, TERM_CMP_MASK);
          end else begin
            next_term_lit[aw_addr[TERM_BLK_BIT]][aw_addr[TERM_IDX_LSB +: TERM_IDX_W]] =
              merge(term_lit[aw_addr[TERM_BLK_BIT]][aw_addr[TERM_IDX_LSB +: TERM_IDX_W]],
                    w_data, w_strb, TERM_LIT_MASK);
          end
        end
        RGN_ROUTE: begin
          next_route_w[aw_addr[ROUTE_BLK_BIT]][aw_addr[ROUTE_IDX_LSB +: ROUTE_IDX_W]] =
            merge(route_w[aw_addr[ROUTE_BLK_BIT]][aw_addr[ROUTE_IDX_LSB +: ROUTE_IDX_W]],
                  w_data, w_strb, ROUTE_MASK);
        end
        RGN_ALLOC: begin
          next_alloc_w[aw_addr[ALLOC_BLK_BIT]] =
            merge(alloc_w[aw_addr[ALLOC_BLK_BIT]], w_data, w_strb, ALLOC_MASK);
        end
        RGN_MC: begin
          next_mc_w[aw_addr[MC_BLK_BIT]][aw_addr[MC_IDX_LSB +: MC_IDX_W]] =
            merge(mc_w[aw_addr[MC_BLK_BIT]][aw_addr[MC_IDX_LSB +: MC_IDX_W]],
                  w_data, w_strb, MC_MASK);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_lit <= '{default: CFG_RESET};
      term_cmp <= '{default: CFG_RESET};
      route_w  <= '{default: CFG_RESET};
      alloc_w  <= '{default: CFG_RESET};
      mc_w     <= '{default: CFG_RESET};
    end else begin
      term_lit <= next_term_lit;
      term_cmp <= next_term_cmp;
      route_w  <= next_route_w;
      alloc_w  <= next_alloc_w;
      mc_w     <= next_mc_w;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic [DATA_W-1:0] rd_word;
  plb_region_type    rd_rgn;

  assign rd_rgn  = region_of(araddr);
  assign arready = !rvalid;

  always_comb begin
    rd_word = '0;
    case (rd_rgn)
      RGN_TERM: rd_word = araddr[WORD_SEL_BIT] ?
        term_cmp[araddr[TERM_BLK_BIT]][araddr[TERM_IDX_LSB +: TERM_IDX_W]] :
        term_lit[araddr[TERM_BLK_BIT]][araddr[TERM_IDX_LSB +: TERM_IDX_W]];
      RGN_ROUTE: rd_word =
        route_w[araddr[ROUTE_BLK_BIT]][araddr[ROUTE_IDX_LSB +: ROUTE_IDX_W]];
      RGN_ALLOC: rd_word = alloc_w[araddr[ALLOC_BLK_BIT]];
      RGN_MC:    rd_word = mc_w[araddr[MC_BLK_BIT]][araddr[MC_IDX_LSB +: MC_IDX_W]];
      RGN_STAT: begin
        case (araddr[STAT_IDX_LSB +: STAT_IDX_W])
          STAT_IO_OUT: rd_word = io_out;
          STAT_IO_OE:  rd_word = io_oe;
          default:     rd_word = io_sync;
        endcase
      end
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = (rd_rgn == RGN_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

endmodule

// [plb_pkg.sv]
/*
  Shared constants for the programmable logic block array: fabric sizes,
  routing source map, configuration field layout and the register map.
  Assumes a 16-bit AXI4-Lite byte address with 32-bit data.
*/
package plb_pkg;

  // ----------------------------------------------------------------
  // fabric sizes
  // ----------------------------------------------------------------
  localparam int NUM_BLOCKS        = 2;
  localparam int NUM_IO            = 32;
  localparam int NUM_DED           = 6;
  localparam int NUM_CLK           = 2;
  localparam int NUM_MC            = 16;
  localparam int NUM_LOGIC_TERMS   = 64;
  localparam int NUM_TERMS         = 70;
  localparam int NUM_IN            = 22;
  localparam int NUM_CLUSTERS      = 16;
  localparam int TERMS_PER_CLUSTER = 4;
  localparam int HALF_SIZE         = 8;
  localparam int BANK_SIZE         = 8;
  localparam int NUM_PIN_RAW       = NUM_IO + NUM_DED + NUM_CLK;

  // ----------------------------------------------------------------
  // special term indices, after the logic terms
  // ----------------------------------------------------------------
  localparam int OE_TERM_BASE = 64;
  localparam int CLEAR_TERM   = 68;
  localparam int SET_TERM     = 69;

  // ----------------------------------------------------------------
  // routing sources
  // ----------------------------------------------------------------
  localparam int NUM_SRC        = 72;
  localparam int SRC_SEL_W      = 7;
  localparam int ROUTE_FIELD_W  = 8;
  localparam int ROUTES_PER_WRD = 4;
  localparam int ROUTE_WORDS    = 6;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  localparam int TERM_EN_BIT    = 31;
  localparam int MC_REG_BIT     = 0;
  localparam int MC_INV_BIT     = 1;
  localparam int MC_TOGGLE_BIT  = 2;
  localparam int MC_CLKSEL_BIT  = 3;
  localparam int MC_OE_LSB      = 4;
  localparam int STEER_W        = 2;

  localparam logic [1:0] STEER_NONE = 2'h0;
  localparam logic [1:0] STEER_DOWN = 2'h1;
  localparam logic [1:0] STEER_OWN  = 2'h2;
  localparam logic [1:0] STEER_UP   = 2'h3;

  localparam logic [1:0] OE_OFF    = 2'h0;
  localparam logic [1:0] OE_ON     = 2'h1;
  localparam logic [1:0] OE_TERM_A = 2'h2;
  localparam logic [1:0] OE_TERM_B = 2'h3;

  localparam logic [31:0] TERM_LIT_MASK = 32'h003fffff;
  localparam logic [31:0] TERM_CMP_MASK = 32'h803fffff;
  localparam logic [31:0] ROUTE_MASK    = 32'h7f7f7f7f;
  localparam logic [31:0] ALLOC_MASK    = 32'hffffffff;
  localparam logic [31:0] MC_MASK       = 32'h0000003f;
  localparam logic [31:0] CFG_RESET     = 32'h00000000;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 16;
  localparam int DATA_W        = 32;
  localparam int STRB_W        = 4;
  localparam int WORD_SEL_BIT  = 2;
  localparam int TERM_IDX_LSB  = 3;
  localparam int TERM_IDX_W    = 7;
  localparam int TERM_BLK_BIT  = 10;
  localparam int ROUTE_BLK_BIT = 5;
  localparam int ROUTE_IDX_LSB = 2;
  localparam int ROUTE_IDX_W   = 3;
  localparam int ALLOC_BLK_BIT = 2;
  localparam int MC_BLK_BIT    = 6;
  localparam int MC_IDX_LSB    = 2;
  localparam int MC_IDX_W      = 4;
  localparam int STAT_IDX_LSB  = 2;
  localparam int STAT_IDX_W    = 2;

  localparam logic [15:0] TERM_BASE  = 16'h0000;
  localparam logic [15:0] ROUTE_BASE = 16'h0800;
  localparam logic [15:0] ALLOC_BASE = 16'h0840;
  localparam logic [15:0] MC_BASE    = 16'h0900;
  localparam logic [15:0] STAT_BASE  = 16'h0a00;

  localparam logic [1:0] STAT_IO_OUT = 2'h0;
  localparam logic [1:0] STAT_IO_OE  = 2'h1;
  localparam logic [1:0] STAT_IO_IN  = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    WR_COLLECT = 3'b001,
    WR_COMMIT  = 3'b010,
    WR_RESP    = 3'b100
  } plb_wr_state_type;

  typedef enum logic [2:0] {
    RGN_NONE, RGN_TERM, RGN_ROUTE, RGN_ALLOC, RGN_MC, RGN_STAT
  } plb_region_type;

endpackage

// [plb_sync.sv]
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes inputs are asynchronous to aclk; bits are not coherent as a word.
*/
`timescale 1ns/10ps
module plb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule

// [plb_macrocell.sv]
/*
  One macrocell: storage element plus output polarity and mode select.
  Assumes clk_tick is a one-cycle pulse on aclk and clear/set are the
  block's shared initialisation terms, sampled on aclk.
*/
`timescale 1ns/10ps
module plb_macrocell (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic sum,
  input  wire logic registered,
  input  wire logic invert,
  input  wire logic toggle,
  input  wire logic clk_tick,
  input  wire logic clear,
  input  wire logic set,
  output logic      out
);

  logic state;
  logic next_state;
  logic next_out;

  // ----------------------------------------------------------------
  // next state and output
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (clear) begin
      next_state = 1'b0;
    end else if (set) begin
      next_state = 1'b1;
    end else if (clk_tick) begin
      next_state = toggle ? (state ^ sum) : sum;
    end
    // output flop follows next_state, so registered mode adds no lag
    next_out = (registered ? next_state : sum) ^ invert;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= 1'b0;
      out   <= 1'b0;
    end else begin
      state <= next_state;
      out   <= next_out;
    end
  end

endmodule

// [plb_monitor.sv]
/* Handshake and reset checks on the fabric top.
   Assumes it is bound onto plb_fabric. */
`timescale 1ns/10ps
module plb_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] io_out,
  input wire logic [31:0] io_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr; awvalid && awready && wvalid && wready; endsequence
  property p_wr; s_wr |-> ##2 bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_bh; bvalid && !bready |=> bvalid; endproperty
  a_bh: assert property (p_bh) else $error("write answer dropped");
  property p_bd; bvalid && bready |=> !bvalid; endproperty
  a_bd: assert property (p_bd) else $error("write answer repeated");
  property p_bb; s_wr |=> !awready && !wready; endproperty
  a_bb: assert property (p_bb) else $error("write taken while busy");
  property p_rd; arvalid && arready |=> rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rh; rvalid && !rready |=> rvalid; endproperty
  a_rh: assert property (p_rh) else $error("read answer dropped");
  property p_ar; rvalid && rready |=> !rvalid; endproperty
  a_ar: assert property (p_ar) else $error("read answer repeated");
  property p_rst; $rose(aresetn) |-> io_out == '0 && io_oe == '0; endproperty
  a_rst: assert property (p_rst) else $error("pins not low at start");
endmodule
bind plb_fabric plb_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .io_out(io_out), .io_oe(io_oe));

// [plb_board.sv]
/* Board logic on the two-way pins.
   Assumes the bench sets what the board drives on each pin. */
`timescale 1ns/10ps
module plb_board (
  input  wire logic [31:0] io_out,
  input  wire logic [31:0] io_oe,
  input  wire logic [31:0] ext,
  output logic      [31:0] io_in
);
  // device wins where it drives, board level elsewhere
  assign io_in = (io_out & io_oe) | (ext & ~io_oe);
endmodule

// [tb_top.sv]
/* Self-checking bench for plb_fabric.
   Assumes plb_pkg, the monitor and the board model are compiled first. */
`timescale 1ns/10ps
module tb_top;
  import plb_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, io_out, io_oe, io_in, ext;
  logic [1:0]  bresp, rresp, clk_pin;
  logic [5:0]  ded_in;
  int          errors, compares;
  plb_fabric u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .ded_in(ded_in), .clk_pin(clk_pin),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  plb_board u_board (.io_out(io_out), .io_oe(io_oe), .ext(ext), .io_in(io_in));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task hang(input int i);
    if (i == 20) begin
      errors++;
      complete_run;
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    // an edge between calls, so bready is never driven twice in one step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    hang(i);
    chk("bresp", bresp, r);
  endtask
  task rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    hang(i);
    chk("rdata", rdata, d);
    chk("rresp", rresp, r);
  endtask
  // pin held high then low long enough to be seen
  task tick(input int b);
    clk_pin[b] <= 1'b1;
    wt(4);
    clk_pin[b] <= 1'b0;
    wt(4);
  endtask
  task t_regs;
    rd(TERM_BASE, CFG_RESET, RESP_OKAY);
    wr(TERM_BASE, 32'hffffffff, RESP_OKAY);
    rd(TERM_BASE, TERM_LIT_MASK, RESP_OKAY);
    rd(16'h0230, 32'h0, RESP_SLVERR);
    wr(STAT_BASE, 32'h1, RESP_SLVERR);
    rd(STAT_BASE, 32'h0, RESP_OKAY);
    $display("end t_regs");
  endtask
  task t_comb;
    wr(ROUTE_BASE, 32'h0, RESP_OKAY);
    wr(TERM_BASE, 32'h1, RESP_OKAY);
    wr(TERM_BASE + 16'h4, 32'h80000000, RESP_OKAY);
    wr(ALLOC_BASE, 32'h2, RESP_OKAY);
    wr(MC_BASE, 32'h10, RESP_OKAY);
    ded_in <= 6'h1;
    wt(6);
    chk("pin0 out", io_out[0], 1'b1);
    chk("pin0 oe", io_oe[0], 1'b1);
    wr(MC_BASE, 32'h12, RESP_OKAY);
    wt(6);
    chk("pin0 inverted", io_out[0], 1'b0);
    ext <= 32'h20;
    wr(ROUTE_BASE, 32'hd, RESP_OKAY);
    wr(MC_BASE, 32'h0, RESP_OKAY);
    wt(6);
    chk("pin5 feedback", io_out[0], 1'b1);
    chk("pin0 released", io_oe[0], 1'b0);
    wr(TERM_BASE + 16'h204, 32'h80000000, RESP_OKAY);
    wr(MC_BASE, 32'h20, RESP_OKAY);
    wr(MC_BASE + 16'h20, 32'h20, RESP_OKAY);
    wt(4);
    chk("bank0 term", io_oe[0], 1'b1);
    chk("bank1 term", io_oe[8], 1'b0);
    $display("end t_comb");
  endtask
  task t_seq;
    wr(ROUTE_BASE, 32'h0, RESP_OKAY);
    wr(MC_BASE, 32'h11, RESP_OKAY);
    wt(8);
    chk("no clock yet", io_out[0], 1'b0);
    tick(0);
    chk("rise capture", io_out[0], 1'b1);
    ded_in <= 6'h0;
    wr(MC_BASE, 32'h19, RESP_OKAY);
    tick(0);
    chk("other clock", io_out[0], 1'b1);
    tick(1);
    chk("own clock", io_out[0], 1'b0);
    ded_in <= 6'h1;
    wr(MC_BASE, 32'h1d, RESP_OKAY);
    tick(1);
    chk("toggle up", io_out[0], 1'b1);
    tick(1);
    chk("toggle down", io_out[0], 1'b0);
    wr(TERM_BASE + 16'h22c, 32'h80000000, RESP_OKAY);
    wt(4);
    chk("set alone", io_out[0], 1'b1);
    wr(TERM_BASE + 16'h224, 32'h80000000, RESP_OKAY);
    wt(4);
    chk("clear and set", io_out[0], 1'b0);
    wr(TERM_BASE + 16'h22c, 32'h0, RESP_OKAY);
    tick(1);
    chk("clear alone", io_out[0], 1'b0);
    wr(TERM_BASE + 16'h224, 32'h0, RESP_OKAY);
    tick(1);
    chk("clocked again", io_out[0], 1'b1);
    $display("end t_seq");
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, ext} = '0;
    ded_in = 6'h0;
    clk_pin = 2'h0;
    errors = 0;
    compares = 0;
    wt(6);
    aresetn <= 1'b1;
    wt(2);
    t_regs;
    t_comb;
    t_seq;
    complete_run;
  end
endmodule
